/* rtl/conv_cfg_pkg.sv */
// constants shared by the converter configuration register block
package conv_cfg_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0]  IDX_PIN_WAY      = 8'h13;
  localparam logic [7:0]  IDX_PIN_LEVEL    = 8'h14;
  localparam logic [7:0]  IDX_AUX_SETUP    = 8'h15;
  localparam logic [7:0]  IDX_AUX_INPUT    = 8'h16;
  localparam logic [31:0] ADDR_PIN_WAY     = {22'h00_0000, IDX_PIN_WAY, 2'b00};
  localparam logic [31:0] ADDR_PIN_LEVEL   = {22'h00_0000, IDX_PIN_LEVEL, 2'b00};
  localparam logic [31:0] ADDR_AUX_SETUP   = {22'h00_0000, IDX_AUX_SETUP, 2'b00};
  localparam logic [31:0] ADDR_AUX_INPUT   = {22'h00_0000, IDX_AUX_INPUT, 2'b00};

  // reset values
  localparam logic [7:0]  RST_PIN_WAY      = 8'h00;
  localparam logic [7:0]  RST_PIN_LEVEL    = 8'h00;
  localparam logic [7:0]  RST_AUX_SETUP    = 8'h00;
  localparam logic [7:0]  RST_AUX_INPUT    = 8'h01;

  // field positions of the auxiliary setup register
  localparam int          RATE_MSB         = 7;
  localparam int          RATE_LSB         = 6;
  localparam int          VREF_MSB         = 5;
  localparam int          VREF_LSB         = 3;
  localparam int          GAIN_MSB         = 2;
  localparam int          GAIN_LSB         = 0;

  // field positions of the auxiliary input select register
  localparam int          POS_MSB          = 7;
  localparam int          POS_LSB          = 4;
  localparam int          NEG_MSB          = 3;
  localparam int          NEG_LSB          = 0;

  // reference codes
  localparam logic [2:0]  VREF_INTERNAL    = 3'h0;
  localparam logic [2:0]  VREF_SUPPLY      = 3'h4;

  // input codes, shared by both input fields
  localparam logic [3:0]  IN_LAST_PIN      = 4'h9;
  localparam logic [3:0]  IN_COMMON        = 4'ha;
  localparam logic [3:0]  IN_TEMP_MON      = 4'hb;
  localparam logic [3:0]  IN_AVDD_MON      = 4'hc;
  localparam logic [3:0]  IN_DVDD_MON      = 4'hd;
  localparam logic [3:0]  IN_TEST_SIGNAL   = 4'he;
  localparam logic [3:0]  IN_OPEN          = 4'hf;

  // data rates in samples per second
  localparam logic [9:0]  SPS_CODE0        = 10'h00a;
  localparam logic [9:0]  SPS_CODE1        = 10'h064;
  localparam logic [9:0]  SPS_CODE2        = 10'h190;
  localparam logic [9:0]  SPS_CODE3        = 10'h320;

  // bus answers
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

endpackage

/* rtl/aux_cfg_if.sv */
// carrier for the two auxiliary converter configuration bytes
`timescale 1ns/1ps
interface aux_cfg_if;
  logic [7:0] setup;        // rate, reference and gain byte
  logic [7:0] inputSelect;  // positive and negative input byte

  modport owner (output setup, output inputSelect);
  modport user  (input setup, input inputSelect);
endinterface

/* rtl/gpio_pin_cell.sv */
// one general-purpose pin: input synchroniser and registered pin drive
`timescale 1ns/1ps
module gpio_pin_cell (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // register side
  input  wire logic levelBit,    // stored level bit
  input  wire logic wayIsInput,  // 1 = pin is an input
  output logic      pinSampled,  // synchronised pin level
  // pin side
  input  wire logic pinIn,
  output logic      pinOut,
  output logic      pinOe
);

  logic syncFirst;  // first stage, read only by the second stage

  // two-stage synchroniser; the pin is asynchronous to clk
  always_ff @(posedge clk) begin
    if (srst) begin
      syncFirst  <= 1'b0;
      pinSampled <= 1'b0;
    end else begin
      syncFirst  <= pinIn;
      pinSampled <= syncFirst;
    end
  end

  // drive only while the pin is an output; 0 is low, 1 is high
  always_ff @(posedge clk) begin
    if (srst) begin
      pinOut <= 1'b0;
      pinOe  <= 1'b0;
    end else begin
      pinOut <= levelBit;
      pinOe  <= ~wayIsInput;
    end
  end

endmodule // gpio_pin_cell

/* rtl/aux_setup_decode.sv */
// decodes the auxiliary converter configuration into settings
`timescale 1ns/1ps
module aux_setup_decode
  import conv_cfg_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // configuration bytes
  aux_cfg_if.user   cfg,
  // decoded settings
  output logic [1:0] auxRateSelect,
  output logic [9:0] auxRateSps,
  output logic [2:0] auxVrefSelect,
  output logic       auxVrefReserved,
  output logic [2:0] auxAmplificationSelect,
  output logic [7:0] auxGainFactor,
  output logic [3:0] auxPositiveInputSelect,
  output logic [3:0] auxNegativeInputSelect,
  output logic       auxPositiveInternal,
  output logic       auxNegativeInternal
);

  logic [1:0] rateCode;  // field views of the setup byte
  logic [2:0] vrefCode;
  logic [2:0] gainCode;

  assign rateCode = cfg.setup[RATE_MSB:RATE_LSB];
  assign vrefCode = cfg.setup[VREF_MSB:VREF_LSB];
  assign gainCode = cfg.setup[GAIN_MSB:GAIN_LSB];

  // rate, reference and gain; registered so every output is a flop
  always_ff @(posedge clk) begin
    if (srst) begin
      auxRateSelect          <= RST_AUX_SETUP[RATE_MSB:RATE_LSB];
      auxRateSps             <= SPS_CODE0;
      auxVrefSelect          <= VREF_INTERNAL;
      auxVrefReserved        <= 1'b0;
      auxAmplificationSelect <= RST_AUX_SETUP[GAIN_MSB:GAIN_LSB];
      auxGainFactor          <= 8'h01;
    end else begin
      auxRateSelect <= rateCode;
      unique case (rateCode)
        2'h0: auxRateSps <= SPS_CODE0;
        2'h1: auxRateSps <= SPS_CODE1;
        2'h2: auxRateSps <= SPS_CODE2;
        2'h3: auxRateSps <= SPS_CODE3;
      endcase
      auxVrefSelect   <= vrefCode;
      // codes above the supply pair are undefined; flagged, not fixed up
      auxVrefReserved <= (vrefCode > VREF_SUPPLY);
      auxAmplificationSelect <= gainCode;
      auxGainFactor   <= 8'(8'h01 << gainCode);
    end
  end

  // input selection; codes past the common input are internal sources
  always_ff @(posedge clk) begin
    if (srst) begin
      auxPositiveInputSelect <= RST_AUX_INPUT[POS_MSB:POS_LSB];
      auxNegativeInputSelect <= RST_AUX_INPUT[NEG_MSB:NEG_LSB];
      auxPositiveInternal    <= 1'b0;
      auxNegativeInternal    <= 1'b0;
    end else begin
      auxPositiveInputSelect <= cfg.inputSelect[POS_MSB:POS_LSB];
      auxNegativeInputSelect <= cfg.inputSelect[NEG_MSB:NEG_LSB];
      auxPositiveInternal    <= cfg.inputSelect[POS_MSB:POS_LSB] > IN_COMMON;
      auxNegativeInternal    <= cfg.inputSelect[NEG_MSB:NEG_LSB] > IN_COMMON;
    end
  end

endmodule // aux_setup_decode

/* rtl/conv_cfg_regs.sv */
// pin level and auxiliary converter configuration registers, AXI4-Lite slave
//
// Overview of operation
// - output pin: level read returns stored bit
// - input pin: write stores bit, pin untouched
// - pin level register resets to 0x00
// - rate field 7:6 picks 10..800 SPS
// - reference field 5:3 picks reference pair
// - gain field 2:0 gives power-of-two gain
// - auxiliary setup register resets to 0x00
// - positive field 7:4 picks input, reset 0
// - codes 1011..1111 select monitors, test, open
// - negative field 3:0, same codes, reset 1
// - input select register resets to 0x01
// - direction bit 0 output, 1 input
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module conv_cfg_regs
  import conv_cfg_pkg::*;
#(
  parameter int PIN_COUNT = 8  // general-purpose pins
)(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // write address channel
  input  wire logic [31:0] awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  // write data channel
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // write response channel
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // read address channel
  input  wire logic [31:0] araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  // read data channel
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // general-purpose pins
  input  wire logic [PIN_COUNT-1:0] gpioIn,
  output logic [PIN_COUNT-1:0]      gpioOut,
  output logic [PIN_COUNT-1:0]      gpioOe,
  // auxiliary converter settings
  output logic [1:0]       auxRateSelect,
  output logic [9:0]       auxRateSps,
  output logic [2:0]       auxVrefSelect,
  output logic             auxVrefReserved,
  output logic [2:0]       auxAmplificationSelect,
  output logic [7:0]       auxGainFactor,
  output logic [3:0]       auxPositiveInputSelect,
  output logic [3:0]       auxNegativeInputSelect,
  output logic             auxPositiveInternal,
  output logic             auxNegativeInternal
);

  // the level and direction registers are one byte each;
  // more pins would need a second register pair and lane decoding
  if (PIN_COUNT != 8) begin : g_bad_width
    $error("conv_cfg_regs: PIN_COUNT must be 8");
  end

  // register storage
  // one byte per register; bus lanes above the low byte are ignored
  logic [PIN_COUNT-1:0] gpioPinWay;    // 1 = input, 0 = output
  logic [PIN_COUNT-1:0] gpioPinLevel;  // stored level bits
  logic [PIN_COUNT-1:0] pinSampled;    // synchronised pin levels
  aux_cfg_if            auxCfg ();     // setup and input select bytes

  // write path state
  // address and data may arrive in either order; each is held until
  // the response handshake, so no second write can start meanwhile
  logic [31:0] wrAddr;     // captured write address
  logic [31:0] wrData;     // captured write data
  logic [3:0]  wrStrb;     // captured byte enables
  logic        wrFire;     // both halves held, response not yet out
  logic        wrHit;      // captured address is a mapped register
  logic        wrByte0;    // low byte lane enabled

  // address and data are held once taken; ready low means held
  // wrFire is high for one cycle per write, the cycle before bvalid
  assign wrFire  = ~awready & ~wready & ~bvalid;
  assign wrByte0 = wrStrb[0];

  // decode of the captured write address
  // exact word match; sub-word offsets are refused like any other miss
  always_comb begin
    unique case (wrAddr)
      ADDR_PIN_WAY,
      ADDR_PIN_LEVEL,
      ADDR_AUX_SETUP,
      ADDR_AUX_INPUT: wrHit = 1'b1;
      default:        wrHit = 1'b0;
    endcase
  end

  // write address channel: take one address, release after the response
  // holding awready low blocks a second write until this one is answered
  always_ff @(posedge clk) begin
    if (srst) begin
      awready <= 1'b1;
      wrAddr  <= 32'h0000_0000;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      wrAddr  <= awaddr;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end
  end

  // write data channel: taken independently of the address
  // data may come before, with or after the address
  always_ff @(posedge clk) begin
    if (srst) begin
      wready <= 1'b1;
      wrData <= 32'h0000_0000;
      wrStrb <= 4'h0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      wrData <= wdata;
      wrStrb <= wstrb;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
    end
  end

  // write response: one cycle after both halves are held
  // an unmapped address stores nothing and is answered with an error
  always_ff @(posedge clk) begin
    if (srst) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wrFire) begin
      bvalid <= 1'b1;
      bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // register updates; only the low byte lane carries data
  // a write with lane 0 disabled is still answered okay but stores nothing

  // pin direction register
  // kept here so a read sees the new direction on the next cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      gpioPinWay <= RST_PIN_WAY;  // all outputs after reset
    end else if (wrFire && wrByte0 && wrAddr == ADDR_PIN_WAY) begin
      gpioPinWay <= wrData[PIN_COUNT-1:0];
    end
  end

  // pin level register; a write always stores, whatever the direction.
  // an input pin is not driven, so the store has no effect on it
  // reset leaves every output pin low
  always_ff @(posedge clk) begin
    if (srst) begin
      gpioPinLevel <= RST_PIN_LEVEL;
    end else if (wrFire && wrByte0 && wrAddr == ADDR_PIN_LEVEL) begin
      gpioPinLevel <= wrData[PIN_COUNT-1:0];
    end
  end

  // auxiliary setup register
  // the decoder sees this byte through the carrier interface
  always_ff @(posedge clk) begin
    if (srst) begin
      auxCfg.setup <= RST_AUX_SETUP;
    end else if (wrFire && wrByte0 && wrAddr == ADDR_AUX_SETUP) begin
      // reserved reference codes are stored as written
      auxCfg.setup <= wrData[7:0];
    end
  end

  // auxiliary input select register
  // reset pairs input zero against input one
  always_ff @(posedge clk) begin
    if (srst) begin
      auxCfg.inputSelect <= RST_AUX_INPUT;
    end else if (wrFire && wrByte0 && wrAddr == ADDR_AUX_INPUT) begin
      auxCfg.inputSelect <= wrData[7:0];
    end
  end

  // read path
  // the answer is captured at the address take, so a slow rready
  // cannot see the data change underneath it
  logic [7:0] levelView;   // level byte as software sees it
  logic [7:0] rdByte;      // selected register byte
  logic       rdHit;       // read address is a mapped register

  // output pins read back the stored bit, input pins the pin itself
  // an input pin reads two cycles late through its synchroniser
  always_comb begin
    levelView = 8'h00;
    for (int i = 0; i < PIN_COUNT; i++) begin
      levelView[i] = gpioPinWay[i] ? pinSampled[i] : gpioPinLevel[i];
    end
  end

  // read decode
  // follows the live address; only used at the edge that takes it
  always_comb begin
    unique case (araddr)
      ADDR_PIN_WAY: begin
        rdByte = gpioPinWay;
        rdHit  = 1'b1;
      end
      ADDR_PIN_LEVEL: begin
        rdByte = levelView;
        rdHit  = 1'b1;
      end
      ADDR_AUX_SETUP: begin
        rdByte = auxCfg.setup;
        rdHit  = 1'b1;
      end
      ADDR_AUX_INPUT: begin
        rdByte = auxCfg.inputSelect;
        rdHit  = 1'b1;
      end
      default: begin
        rdByte = 8'h00;
        rdHit  = 1'b0;
      end
    endcase
  end

  // read address channel: one read at a time
  // arready low until the data handshake keeps reads from overlapping
  always_ff @(posedge clk) begin
    if (srst) begin
      arready <= 1'b1;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
    end else if (rvalid && rready) begin
      arready <= 1'b1;
    end
  end

  // read data: answered the cycle after the address is taken;
  // upper bits read as zero, unmapped addresses answer an error
  // data and answer stand with rvalid until rready is seen high
  always_ff @(posedge clk) begin
    if (srst) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= {24'h00_0000, rdByte};
      rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // pins and decoded settings
  // both sit one register behind the stored bytes so every output is a flop

  // one cell per pin: bit n belongs to pin n
  // each cell synchronises its own pin; bits are not sampled as one word
  for (genvar n = 0; n < PIN_COUNT; n++) begin : g_pin
    gpio_pin_cell u_cell (
      .clk        (clk),
      .srst       (srst),
      .levelBit   (gpioPinLevel[n]),
      .wayIsInput (gpioPinWay[n]),
      .pinSampled (pinSampled[n]),
      .pinIn      (gpioIn[n]),
      .pinOut     (gpioOut[n]),
      .pinOe      (gpioOe[n])
    );
  end

  // settings for the auxiliary converter
  // decoded values are registered inside the decoder, one cycle late
  aux_setup_decode u_decode (
    .clk                    (clk),
    .srst                   (srst),
    .cfg                    (auxCfg),
    .auxRateSelect          (auxRateSelect),
    .auxRateSps             (auxRateSps),
    .auxVrefSelect          (auxVrefSelect),
    .auxVrefReserved        (auxVrefReserved),
    .auxAmplificationSelect (auxAmplificationSelect),
    .auxGainFactor          (auxGainFactor),
    .auxPositiveInputSelect (auxPositiveInputSelect),
    .auxNegativeInputSelect (auxNegativeInputSelect),
    .auxPositiveInternal    (auxPositiveInternal),
    .auxNegativeInternal    (auxNegativeInternal)
  );

endmodule // conv_cfg_regs

/* tb/conv_cfg_regs_assertions.sv */
// concurrent checks on the ports of the converter configuration register block
`timescale 1ns/1ps
module conv_cfg_regs_assertions
  import conv_cfg_pkg::*;
#(
  parameter int PIN_COUNT = 8  // general-purpose pins
)(
  // clock and reset
  input wire logic                 clk,
  input wire logic                 srst,
  // bus handshakes and payload
  input wire logic [31:0]          awaddr,
  input wire logic                 awvalid,
  input wire logic                 awready,
  input wire logic [31:0]          wdata,
  input wire logic [3:0]           wstrb,
  input wire logic                 wvalid,
  input wire logic                 wready,
  input wire logic                 bvalid,
  input wire logic                 arvalid,
  input wire logic                 arready,
  input wire logic [31:0]          rdata,
  input wire logic                 rvalid,
  input wire logic                 rready,
  // pins and settings
  input wire logic [PIN_COUNT-1:0] gpioOut,
  input wire logic [PIN_COUNT-1:0] gpioOe,
  input wire logic [1:0]           auxRateSelect,
  input wire logic [9:0]           auxRateSps,
  input wire logic [2:0]           auxVrefSelect,
  input wire logic                 auxVrefReserved,
  input wire logic [2:0]           auxAmplificationSelect,
  input wire logic [7:0]           auxGainFactor,
  input wire logic [3:0]           auxPositiveInputSelect,
  input wire logic [3:0]           auxNegativeInputSelect,
  input wire logic                 auxPositiveInternal,
  input wire logic                 auxNegativeInternal
);
  // one clock domain, so one default clocking and disable
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // both write halves taken at one edge
  sequence s_wtake;
    awvalid && awready && wvalid && wready;
  endsequence
  // a write to one register with its byte lane enabled
  sequence s_wtake_at(logic [31:0] a);
    s_wtake ##0 (awaddr == a) && wstrb[0];
  endsequence
  // written byte shows on the output three edges after the take
  property p_lands(logic [31:0] a, logic [7:0] o);
    logic [7:0] v;
    (s_wtake_at(a), v = wdata[7:0]) |-> ##3 (o == v);
  endproperty

  a_level_drive: assert property (p_lands(ADDR_PIN_LEVEL, gpioOut))
    else $error("pin drive does not follow written level");
  a_way_enable: assert property (p_lands(ADDR_PIN_WAY, ~gpioOe))
    else $error("pin enable does not follow direction");
  a_setup_fields: assert property (p_lands(ADDR_AUX_SETUP,
    {auxRateSelect, auxVrefSelect, auxAmplificationSelect}))
    else $error("setup fields do not follow write");
  a_input_fields: assert property (p_lands(ADDR_AUX_INPUT,
    {auxPositiveInputSelect, auxNegativeInputSelect}))
    else $error("input fields do not follow write");
  a_reset_load: assert property ($fell(srst) |->
    gpioOut == 8'h00 && auxRateSelect == 2'h0
    && auxVrefSelect == 3'h0 && auxAmplificationSelect == 3'h0
    && {auxPositiveInputSelect, auxNegativeInputSelect} == 8'h01)
    else $error("outputs not at reset values");
  a_gain_power: assert property (auxGainFactor == (8'h01 << auxAmplificationSelect))
    else $error("gain factor not a power of two of the code");
  a_rate_table: assert property (auxRateSps == (
    (auxRateSelect == 2'h0) ? 10'h00a : (auxRateSelect == 2'h1) ? 10'h064 :
    (auxRateSelect == 2'h2) ? 10'h190 : 10'h320))
    else $error("rate does not match code");
  a_vref_flag: assert property (auxVrefReserved == (auxVrefSelect > 3'h4))
    else $error("reserved reference flag wrong");
  a_internal_flags: assert property (
    auxPositiveInternal == (auxPositiveInputSelect > 4'ha)
    && auxNegativeInternal == (auxNegativeInputSelect > 4'ha))
    else $error("internal input flags wrong");
  a_write_answer: assert property (s_wtake |=> !awready && !wready ##1 bvalid)
    else $error("write answer late or ready not dropped");
  a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer late");
  a_read_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped before taken");
endmodule // conv_cfg_regs_assertions

bind conv_cfg_regs conv_cfg_regs_assertions #(.PIN_COUNT(PIN_COUNT)) chk (
  .clk, .srst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bvalid,
  .arvalid, .arready, .rdata, .rvalid, .rready, .gpioOut, .gpioOe, .auxRateSelect,
  .auxRateSps, .auxVrefSelect, .auxVrefReserved, .auxAmplificationSelect, .auxGainFactor,
  .auxPositiveInputSelect, .auxNegativeInputSelect, .auxPositiveInternal,
  .auxNegativeInternal
);

/* tb/tb_conv_cfg_regs.sv */
// self-checking bench for the converter configuration register block
`timescale 1ns/1ps
module tb_conv_cfg_regs;
  import conv_cfg_pkg::*;
  logic        clk, srst, awvalid, wvalid, bready, arvalid, rready;    // bench driven
  logic        awready, wready, bvalid, arready, rvalid;               // slave handshakes
  logic [31:0] awaddr, wdata, araddr, rdata;                           // bus payload
  logic [3:0]  wstrb;                                                  // byte lanes
  logic [2:0]  awprot, arprot;                                         // protection
  logic [1:0]  bresp, rresp;                                           // answers
  logic [7:0]  gpioIn, gpioOut, gpioOe, auxGainFactor, way, level, v; // pins, model
  logic [9:0]  auxRateSps;
  logic [1:0]  auxRateSelect;
  logic [2:0]  auxVrefSelect, auxAmplificationSelect;
  logic [3:0]  auxPositiveInputSelect, auxNegativeInputSelect;
  logic        auxVrefReserved, auxPositiveInternal, auxNegativeInternal;
  logic [9:0]  sps [4] = '{10'h00a, 10'h064, 10'h190, 10'h320};      // rate per code
  logic [33:0] rdExp [$];                                              // {resp, data} notes
  logic [1:0]  wrExp [$];                                              // write answer notes
  int          failures, checksDone, seedVal;

  conv_cfg_regs #(.PIN_COUNT(8)) dut (.clk, .srst, .awaddr, .awprot, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .gpioIn, .gpioOut, .gpioOe, .auxRateSelect,
    .auxRateSps, .auxVrefSelect, .auxVrefReserved, .auxAmplificationSelect, .auxGainFactor,
    .auxPositiveInputSelect, .auxNegativeInputSelect, .auxPositiveInternal,
    .auxNegativeInternal);

  // compare tasks, one per kind of result
  task automatic cmp_read(logic [33:0] e, logic [33:0] g);
    checksDone++;
    if (g !== e) begin
      failures++;
      $display("mismatch read expected %h seen %h", e, g);
    end
  endtask
  task automatic cmp_resp(logic [1:0] e, logic [1:0] g);
    checksDone++;
    if (g !== e) begin
      failures++;
      $display("mismatch bresp expected %h seen %h", e, g);
    end
  endtask
  task automatic cmp_out(string n, logic [9:0] e, logic [9:0] g);
    checksDone++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic give_verdict();
    if (failures == 0 && checksDone > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // write: address and data offered together, each dropped when taken
  task automatic wr(logic [31:0] a, logic [7:0] d, logic [3:0] s, logic [1:0] er);
    logic done;
    wrExp.push_back(er);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= {24'h00_0000, d};
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  // read: rready raised late so the slave must hold its answer
  task automatic rd(logic [31:0] a, logic [33:0] e);
    logic done;
    rdExp.push_back(e);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1 && rready === 1'b1) begin
        rready <= 1'b0;
        done = 1'b1;
      end else if (rvalid === 1'b1) rready <= 1'b1;
    end
  endtask

  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // monitor: oldest note against each answer as it is taken
  always @(posedge clk) begin
    if ((bvalid & bready) === 1'b1) cmp_resp(wrExp.pop_front(), bresp);
    if ((rvalid & rready) === 1'b1) cmp_read(rdExp.pop_front(), {rresp, rdata});
  end

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200_000;
    failures++;
    give_verdict();
  end

  // main sequence
  initial begin
    seedVal = $urandom(6);
    {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
    {awaddr, wdata, araddr} <= 96'h0;
    {wstrb, awprot, arprot} <= 10'h000;
    gpioIn <= 8'h00;
    srst   <= 1'b1;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rd(ADDR_PIN_WAY, {2'b00, 32'h0000_0000});
    rd(ADDR_PIN_LEVEL, {2'b00, 32'h0000_0000});
    rd(ADDR_AUX_SETUP, {2'b00, 32'h0000_0000});
    rd(ADDR_AUX_INPUT, {2'b00, 32'h0000_0001});
    rd(32'h0000_0060, {2'b10, 32'h0000_0000});
    wr(32'h0000_0060, 8'h5a, 4'h1, 2'b10);
    // every rate and gain code; reference codes stop short of the reserved ones
    for (int i = 0; i < 8; i++) begin
      v = {i[1:0], 3'(i % 5), i[2:0]};
      wr(ADDR_AUX_SETUP, v, 4'h1, 2'b00);
      rd(ADDR_AUX_SETUP, {26'h000_0000, v});
      cmp_out("rate", sps[i % 4], auxRateSps);
      cmp_out("gain", {2'b00, 8'h01 << i}, {2'b00, auxGainFactor});
      cmp_out("vref", {9'h000, 3'(i % 5) > VREF_SUPPLY}, {9'h000, auxVrefReserved});
    end
    // disabled byte lane leaves the register alone but is answered okay
    wr(ADDR_AUX_SETUP, 8'h00, 4'h0, 2'b00);
    rd(ADDR_AUX_SETUP, {26'h000_0000, v});
    // every input code on both fields
    for (int i = 0; i < 16; i++) begin
      v = {i[3:0], 4'hf - i[3:0]};
      wr(ADDR_AUX_INPUT, v, 4'h1, 2'b00);
      rd(ADDR_AUX_INPUT, {26'h000_0000, v});
      cmp_out("flags", {8'h00, i > 10, i < 5},
        {8'h00, auxPositiveInternal, auxNegativeInternal});
    end
    // random directions, levels and pin inputs
    for (int k = 0; k < 6; k++) begin
      way = 8'($urandom);
      level = 8'($urandom);
      gpioIn <= 8'($urandom);
      wr(ADDR_PIN_WAY, way, 4'h1, 2'b00);
      wr(ADDR_PIN_LEVEL, level, 4'h1, 2'b00);
      repeat (4) @(posedge clk);
      rd(ADDR_PIN_LEVEL, {26'h000_0000, (level & ~way) | (gpioIn & way)});
      cmp_out("pins", {2'b00, level}, {2'b00, gpioOut});
      cmp_out("enable", {2'b00, ~way}, {2'b00, gpioOe});
    end
    repeat (3) @(posedge clk);
    give_verdict();
  end
endmodule // tb_conv_cfg_regs
